/* logic/rsq_pkg.sv */
// Purpose: Shared constants and state types of the reset sequencer.
// Assumes: 125 MHz system clock, AHB-Lite register access.
// Notes:   All offsets are byte addresses of 32-bit words.
package rsq_pkg;

   // Timing
   localparam int CLK_PERIOD_NS  = 8;
   localparam int PWR_UP_DLY_NS  = 300000;
   localparam int PWR_UP_DLY_CYC = PWR_UP_DLY_NS / CLK_PERIOD_NS;
   localparam int DLY_W          = 16;
   localparam int WDT_DIV        = 12;
   localparam int WDT_DIV_W      = 4;

   // Register map
   localparam logic [7:0] ADDR_CAUSE    = 8'h00;
   localparam logic [7:0] ADDR_MON      = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

   // Field positions
   localparam int PIN_FLAG_BIT    = 0;
   localparam int POR_FLAG_BIT    = 1;
   localparam int MON_SRC_BIT     = 1;
   localparam int SW_RST_BIT      = 4;
   localparam int SUPPLY_STAT_BIT = 6;
   localparam int MON_EN_BIT      = 7;
   localparam int IRQ_REL_BIT     = 0;
   localparam int IRQ_SAG_BIT     = 1;
   localparam int IRQ_W           = 2;

   // Reset values and bus transfer size
   localparam logic [7:0]  PORT_RESET_VAL = 8'hff;
   localparam logic [15:0] BOOT_ADDR      = 16'h0000;
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;

   typedef enum logic [1:0] {
      ST_POWER_UP,
      ST_RELEASE_DLY,
      ST_HOLD,
      ST_RUN
   } rsq_state_e;

   typedef enum logic [1:0] {
      CS_POWER,
      CS_SUPPLY,
      CS_PIN,
      CS_SOFT
   } rsq_cause_e;

   typedef struct packed {
      rsq_state_e           st;
      rsq_cause_e           cause;
      logic [DLY_W-1:0]     dly;
      logic                 core_rst;
      logic                 pin_oe;
      logic [7:0]           port_latch;
      logic                 port_od;
      logic                 pullup_en;
      logic                 irq_dis;
      logic                 ram_protect;
      logic                 pc_clear;
      logic                 clk_int;
      logic                 wdt_en;
      logic [WDT_DIV_W-1:0] wdt_div;
      logic                 wdt_tick;
      logic [15:0]          boot_addr;
      logic                 por_flag;
      logic                 pin_flag;
      logic                 mon_en;
      logic                 mon_src;
      logic                 sw_req;
      logic [IRQ_W-1:0]     irq_stat;
      logic [IRQ_W-1:0]     irq_mask;
      logic                 irq;
      logic [31:0]          hrdata;
      logic                 hreadyout;
      logic                 wr_pend;
      logic [7:0]           wr_addr;
   } rsq_regs_s;

endpackage

/* logic/rsq_top.sv */
// Purpose: Central reset sequencer with AHB-Lite control registers.
// Assumes: supply_ok and rst_pin_in are synchronous to clk; sys_rst is power-on detect.
// Notes:   Control bits that must survive a warm reset sit outside the warm reset path.
`timescale 1ns/1ns

// Contract
// - On reset entry the core halts, registers take reset values, ports go known, interrupts and timers stop.
// - Reset never writes data memory; memory writes stay blocked for the whole reset.
// - In reset the port latches read all ones in open-drain mode and weak pullups stay enabled always.
// - For power-on and supply resets the reset pin is driven low for the whole reset.
// - On release the program counter clears and the clock reverts to the internal oscillator.
// - On release the watchdog is enabled, ticking at the system clock divided by twelve.
// - After every reset instruction fetch starts at address zero.
// - At power-up reset holds with the pin low until supply is good, then for the release delay.
// - Leaving a power-on reset sets the power-on cause flag, bit one of the cause register.
// - Any reset other than power-on clears the power-on cause flag.
// - A power-on reset leaves the supply monitor enabled.
// - Other resets keep the supply monitor enable as it was.
// - A supply reset releases as soon as supply returns, without the power-up delay.
// - Leaving a pin reset sets the pin reset cause flag, bit zero of the cause register.
module rsq_top
   import rsq_pkg::*;
#(
   parameter logic [DLY_W-1:0] PWR_UP_DLY = DLY_W'(PWR_UP_DLY_CYC)
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        supply_ok,
   input  wire logic        rst_pin_in,
   output logic             rst_pin_out,
   output logic             rst_pin_oe,
   output logic             core_rst,
   output logic [7:0]       port_latch,
   output logic             port_open_drain,
   output logic             weak_pullup_en,
   output logic             irq_timer_disable,
   output logic             ram_write_block,
   output logic             pc_clear,
   output logic             clk_sel_internal,
   output logic             wdt_en,
   output logic             wdt_tick,
   output logic [15:0]      boot_addr,
   output logic             irq,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata
);

   rsq_regs_s s;
   rsq_regs_s n;
   logic      bus_acc;
   logic      bus_hit;

   assign bus_acc = hsel && htrans[1] && hready;
   assign bus_hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

   always_comb begin
      logic             do_exit;
      logic             do_enter;
      rsq_cause_e       new_cause;
      logic [IRQ_W-1:0] set_ev;
      logic [IRQ_W-1:0] clr_ev;
      do_exit   = 1'b0;
      do_enter  = 1'b0;
      new_cause = CS_SOFT;
      set_ev    = '0;
      clr_ev    = '0;
      n          = s;
      n.pc_clear = 1'b0;
      n.wdt_tick = 1'b0;

      // Data phase of a write; the core cannot write while held in reset
      if (s.wr_pend && !s.core_rst) begin
         case (s.wr_addr)
            ADDR_CAUSE: begin
               n.mon_src = hwdata[MON_SRC_BIT];
               n.sw_req  = hwdata[SW_RST_BIT];
            end
            ADDR_MON: begin
               n.mon_en = hwdata[MON_EN_BIT];
            end
            ADDR_IRQ_MASK: begin
               n.irq_mask = hwdata[IRQ_W-1:0];
            end
            default: begin
               n.mon_en = s.mon_en;
            end
         endcase
      end

      // Address phase
      n.wr_pend = bus_acc && bus_hit && hwrite && (hsize == HSIZE_WORD);
      n.wr_addr = haddr[7:0];
      if (bus_acc && !hwrite) begin
         n.hrdata = 32'h00000000;
         if (bus_hit) begin
            case (haddr[7:0])
               ADDR_CAUSE: begin
                  n.hrdata[PIN_FLAG_BIT] = s.pin_flag;
                  n.hrdata[POR_FLAG_BIT] = s.por_flag;
               end
               ADDR_MON: begin
                  n.hrdata[MON_EN_BIT]      = s.mon_en;
                  n.hrdata[SUPPLY_STAT_BIT] = supply_ok;
               end
               ADDR_IRQ_STAT: begin
                  n.hrdata[IRQ_W-1:0] = s.irq_stat;
                  clr_ev              = s.irq_stat;
               end
               ADDR_IRQ_MASK: begin
                  n.hrdata[IRQ_W-1:0] = s.irq_mask;
               end
               default: begin
                  n.hrdata = 32'h00000000;
               end
            endcase
         end
      end

      case (s.st)
         ST_POWER_UP: begin
            n.pin_oe = 1'b1;
            if (supply_ok) begin
               n.st  = ST_RELEASE_DLY;
               n.dly = '0;
            end
         end
         ST_RELEASE_DLY: begin
            if (!supply_ok) begin
               n.st = ST_POWER_UP;
            end else if (s.dly == PWR_UP_DLY - DLY_W'(1)) begin
               do_exit = 1'b1;
            end else begin
               n.dly = s.dly + DLY_W'(1);
            end
         end
         ST_HOLD: begin
            case (s.cause)
               // no delay after a supply reset
               CS_SUPPLY: do_exit = supply_ok;
               CS_PIN:    do_exit = rst_pin_in;
               default:   do_exit = 1'b1;
            endcase
         end
         ST_RUN: begin
            if (s.wdt_en) begin
               if (s.wdt_div == WDT_DIV_W'(WDT_DIV - 1)) begin
                  n.wdt_div  = '0;
                  n.wdt_tick = 1'b1;
               end else begin
                  n.wdt_div = s.wdt_div + WDT_DIV_W'(1);
               end
            end
            if (s.mon_en && !supply_ok && !s.mon_src) begin
               set_ev[IRQ_SAG_BIT] = 1'b1;
            end
            // requests take the core at the next edge
            if (s.mon_en && s.mon_src && !supply_ok) begin
               do_enter  = 1'b1;
               new_cause = CS_SUPPLY;
            end else if (!rst_pin_in) begin
               do_enter  = 1'b1;
               new_cause = CS_PIN;
            end else if (s.sw_req) begin
               do_enter  = 1'b1;
               new_cause = CS_SOFT;
            end
         end
         default: begin
            n.st = ST_POWER_UP;
         end
      endcase

      // reset entry; monitor enable left alone
      if (do_enter) begin
         n.st          = ST_HOLD;
         n.cause       = new_cause;
         n.core_rst    = 1'b1;
         n.port_latch  = PORT_RESET_VAL;
         n.port_od     = 1'b1;
         n.irq_dis     = 1'b1;
         n.ram_protect = 1'b1;
         n.wdt_en      = 1'b0;
         // Timer stops at once, no stray tick in reset
         n.wdt_div     = '0;
         n.wdt_tick    = 1'b0;
         n.mon_src     = 1'b0;
         n.irq_mask    = '0;
         n.sw_req      = 1'b0;
         n.clk_int     = 1'b1;
         // drive the pin only for supply resets here
         n.pin_oe      = (new_cause == CS_SUPPLY);
      end

      if (do_exit) begin
         n.st          = ST_RUN;
         n.core_rst    = 1'b0;
         n.pin_oe      = 1'b0;
         n.irq_dis     = 1'b0;
         n.ram_protect = 1'b0;
         n.pc_clear    = 1'b1;
         n.clk_int     = 1'b1;
         n.boot_addr   = BOOT_ADDR;
         n.wdt_en      = 1'b1;
         n.wdt_div     = '0;
         n.por_flag    = (s.cause == CS_POWER);
         n.pin_flag    = (s.cause == CS_PIN);
         set_ev[IRQ_REL_BIT] = 1'b1;
      end

      // Set wins over read clear
      n.irq_stat = (s.irq_stat & ~clr_ev) | set_ev;
      n.irq      = |(n.irq_stat & n.irq_mask);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s             <= '0;
         s.st          <= ST_POWER_UP;
         s.cause       <= CS_POWER;
         s.core_rst    <= 1'b1;
         s.pin_oe      <= 1'b1;
         s.port_latch  <= PORT_RESET_VAL;
         s.port_od     <= 1'b1;
         s.pullup_en   <= 1'b1;
         s.irq_dis     <= 1'b1;
         s.ram_protect <= 1'b1;
         s.clk_int     <= 1'b1;
         s.boot_addr   <= BOOT_ADDR;
         s.mon_en      <= 1'b1;
         s.hreadyout   <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign rst_pin_out       = 1'b0;
   assign rst_pin_oe        = s.pin_oe;
   assign core_rst          = s.core_rst;
   assign port_latch        = s.port_latch;
   assign port_open_drain   = s.port_od;
   assign weak_pullup_en    = s.pullup_en;
   assign irq_timer_disable = s.irq_dis;
   assign ram_write_block   = s.ram_protect;
   assign pc_clear          = s.pc_clear;
   assign clk_sel_internal  = s.clk_int;
   assign wdt_en            = s.wdt_en;
   assign wdt_tick          = s.wdt_tick;
   assign boot_addr         = s.boot_addr;
   assign irq               = s.irq;
   assign hreadyout         = s.hreadyout;
   assign hresp             = 1'b0;
   assign hrdata            = s.hrdata;

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_port_reset: assert property (s.core_rst |-> (s.port_latch == 8'hff) && s.port_od
      && s.pullup_en && s.irq_dis && s.ram_protect && !s.wdt_en)
      else $error("reset outputs not in known state");
   a_ram_guard: assert property ($fell(s.core_rst) |-> $past(s.ram_protect))
      else $error("memory write block missing in reset");
   a_pin_drive: assert property (s.pin_oe |-> s.core_rst && s.cause inside {CS_POWER, CS_SUPPLY})
      else $error("reset pin driven outside power or supply reset");
   a_por_pin: assert property (s.st inside {ST_POWER_UP, ST_RELEASE_DLY} |-> s.pin_oe)
      else $error("pin not low during power-up");
   a_boot_state: assert property ($fell(s.core_rst) |-> s.pc_clear && s.clk_int
      && (s.boot_addr == 16'h0000))
      else $error("release did not clear pc or select internal clock");
   a_wdt_start: assert property ($fell(s.core_rst) |-> s.wdt_en ##12 s.wdt_tick)
      else $error("watchdog tick not twelve cycles after release");
   a_tick_idle: assert property (!s.wdt_en |-> !s.wdt_tick)
      else $error("watchdog tick while timer disabled");
   a_mon_por: assert property ($fell(s.core_rst) && $past(s.cause) == CS_POWER
      |-> s.mon_en)
      else $error("monitor not enabled after power-on");
   a_por_flags: assert property ($fell(s.core_rst) && $past(s.cause) == CS_POWER
      |-> s.por_flag && $past(s.dly) == PWR_UP_DLY - DLY_W'(1))
      else $error("power-on exit flag or delay wrong");
   a_warm_flags: assert property ($fell(s.core_rst) && $past(s.cause) != CS_POWER
      |-> !s.por_flag && (s.pin_flag == ($past(s.cause) == CS_PIN)))
      else $error("warm reset flags wrong");
   a_mon_keep: assert property (s.core_rst && s.cause != CS_POWER |=> $stable(s.mon_en))
      else $error("monitor enable changed by warm reset");
   a_supply_fast: assert property (s.st == ST_HOLD && s.cause == CS_SUPPLY && supply_ok
      |=> !s.core_rst)
      else $error("supply reset not released at once");
   a_req_entry: assert property (s.st == ST_RUN && !rst_pin_in |=> s.core_rst)
      else $error("pin request did not reset core");

endmodule

/* tb/rsq_far_side.sv */
// Purpose: Far side of the sequencer: external reset circuit and supply monitor.
// Assumes: Reset pin has an external pull-up; every party only pulls it low.
// Notes:   Bench commands the external pull and the supply level.
`timescale 1ns/1ns
module rsq_far_side (
   input  wire logic ext_pull,
   input  wire logic supply_good,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      pin_level,
   output logic      supply_ok
);
   // Wired low with pull-up, either party pulling wins
   assign pin_level = !((pin_oe && !pin_out) || ext_pull);
   assign supply_ok = supply_good;
endmodule

/* tb/rsq_top_tb_top.sv */
// Purpose: Self-checking bench of the reset sequencer.
// Assumes: Power-up delay shortened to 16 cycles.
// Notes:   Bus tasks wait on hreadyout under a bound.
`timescale 1ns/1ns
module rsq_top_tb_top;
   import rsq_pkg::*;
   localparam int DLY = 16;
   logic        clk = 1'b0, sys_rst = 1'b1, supply_good = 1'b0, ext_pull = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = HSIZE_WORD;
   logic        supply_ok, pin_level, pin_out, pin_oe, core_rst, od, pu, itd, rwb, pcc;
   logic        csel, wdt_en, wdt_tick, irq, hreadyout, hresp;
   logic [7:0]  port_latch;
   logic [15:0] boot_addr;
   logic [31:0] hrdata, rd;
   int          bad_count = 0, checks = 0, n;

   rsq_top #(.PWR_UP_DLY(DLY_W'(DLY))) DUT (.clk(clk), .sys_rst(sys_rst),
      .supply_ok(supply_ok), .rst_pin_in(pin_level), .rst_pin_out(pin_out),
      .rst_pin_oe(pin_oe), .core_rst(core_rst), .port_latch(port_latch),
      .port_open_drain(od), .weak_pullup_en(pu), .irq_timer_disable(itd),
      .ram_write_block(rwb), .pc_clear(pcc), .clk_sel_internal(csel), .wdt_en(wdt_en),
      .wdt_tick(wdt_tick), .boot_addr(boot_addr), .irq(irq), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   rsq_far_side far (.ext_pull(ext_pull), .supply_good(supply_good), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_level(pin_level), .supply_ok(supply_ok));

   initial begin
      forever #4 clk = ~clk;
   end

   task automatic conclude();
      if (bad_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   // Waits for core_rst to reach a level, counting edges
   task automatic wait_rst(input logic lvl, output int k);
      k = 0;
      do begin step(); k++; end while (core_rst !== lvl && k < 200);
      if (k >= 200) begin
         chk("core_rst wait", 32'(lvl), 32'(core_rst));
         conclude();
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int k;
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      k = 0;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 100);
      rd = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
      if (k >= 100) begin
         chk("hready wait", 32'h1, 32'h0);
         conclude();
      end
   endtask

   task automatic t_power_up();
      repeat (5) step();
      chk("reset outputs", {23'h0, 9'h1ff}, {23'h0, core_rst, pin_oe, od, pu, itd, rwb, 3'h7});
      chk("port latch", 32'(PORT_RESET_VAL), 32'(port_latch));
      chk("wdt in reset", 32'h0, 32'(wdt_en));
      @(posedge clk);
      supply_good <= 1'b1;
      wait_rst(1'b0, n);
      chk("power-up delay", 32'(DLY + 1), 32'(n));
      chk("release outputs", 32'h1f, {27'h0, pcc, csel, wdt_en, !itd, !pin_oe});
      chk("boot address", 32'(BOOT_ADDR), 32'(boot_addr));
      chk("pullups after", 32'h3, {30'h0, od, pu});
      n = 0;
      do begin step(); n++; end while (wdt_tick !== 1'b1 && n < 40);
      chk("first wdt tick", 32'(WDT_DIV), 32'(n));
      n = 0;
      do begin step(); n++; end while (wdt_tick !== 1'b1 && n < 40);
      chk("wdt period", 32'(WDT_DIV), 32'(n));
      bus(ADDR_CAUSE, 1'b0, 32'h0);
      chk("cause after power-on", 32'h2, rd & 32'h2);
      bus(ADDR_MON, 1'b0, 32'h0);
      chk("monitor after power-on", 32'hc0, rd);
   endtask

   task automatic t_irq();
      chk("irq masked", 32'h0, 32'(irq));
      bus(ADDR_IRQ_MASK, 1'b1, 32'h1);
      step();
      chk("irq raised", 32'h1, 32'(irq));
      bus(ADDR_IRQ_STAT, 1'b0, 32'h0);
      chk("irq status", 32'h1, rd);
      step();
      chk("irq cleared", 32'h0, 32'(irq));
      bus(ADDR_IRQ_STAT, 1'b0, 32'h0);
      chk("irq status cleared", 32'h0, rd);
      bus(8'h40, 1'b1, 32'hffffffff);
      bus(8'h40, 1'b0, 32'h0);
      chk("unmapped read", 32'h0, rd);
   endtask

   task automatic t_pin();
      @(posedge clk);
      ext_pull <= 1'b1;
      wait_rst(1'b1, n);
      step();
      chk("pin reset state", 32'h2, {30'h0, itd, wdt_en});
      chk("pin reset ram", 32'h1, 32'(rwb));
      @(posedge clk);
      ext_pull <= 1'b0;
      wait_rst(1'b0, n);
      chk("pin release", 32'h1, 32'(n));
      bus(ADDR_CAUSE, 1'b0, 32'h0);
      chk("cause after pin", 32'h1, rd & 32'h3);
      bus(ADDR_IRQ_MASK, 1'b0, 32'h0);
      chk("mask reset", 32'h0, rd);
   endtask

   task automatic t_soft();
      bus(ADDR_MON, 1'b1, 32'h0);
      bus(ADDR_CAUSE, 1'b1, 32'h10);
      wait_rst(1'b1, n);
      wait_rst(1'b0, n);
      chk("soft reset length", 32'h1, 32'(n));
      bus(ADDR_MON, 1'b0, 32'h0);
      chk("monitor kept off", 32'h40, rd);
      bus(ADDR_CAUSE, 1'b0, 32'h0);
      chk("cause after soft", 32'h0, rd & 32'h2);
   endtask

   task automatic t_supply();
      bus(ADDR_MON, 1'b1, 32'h80);
      bus(ADDR_IRQ_MASK, 1'b1, 32'h2);
      @(posedge clk);
      supply_good <= 1'b0;
      repeat (3) step();
      chk("sag irq", 32'h1, 32'(irq));
      chk("sag no reset", 32'h0, 32'(core_rst));
      @(posedge clk);
      supply_good <= 1'b1;
      bus(ADDR_IRQ_STAT, 1'b0, 32'h0);
      chk("sag status", 32'h2, rd & 32'h2);
      bus(ADDR_CAUSE, 1'b1, 32'h2);
      @(posedge clk);
      supply_good <= 1'b0;
      wait_rst(1'b1, n);
      repeat (30) step();
      chk("supply reset", 32'h3, {30'h0, core_rst, pin_oe});
      @(posedge clk);
      supply_good <= 1'b1;
      wait_rst(1'b0, n);
      chk("no power-up delay", 32'h1, 32'(n));
      bus(ADDR_MON, 1'b0, 32'h0);
      chk("monitor kept on", 32'hc0, rd);
      bus(ADDR_CAUSE, 1'b0, 32'h0);
      chk("cause after supply", 32'h0, rd & 32'h2);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      t_power_up();
      t_irq();
      t_pin();
      t_soft();
      t_supply();
      conclude();
   end
endmodule
